// *** hdl/csm_obs_mux.sv ***
/*
  Observation pin selection and channel-4 comparator feedback for the
  current sense block. Holds the two pin config words and the negative
  current threshold, drives the analog mux controls of both pins and
  hands the channel-4 comparator results to the microcore.
  Assumes register writes come from the digital cores or the serial port
  bridge, synchronous to ref_clk, and that the channel-4 amplifier level is
  presented as a digitised sample in DAC LSB units with fractional bits.
  Both pins may be enabled together; keeping a shared converter input to
  one driver is left to the host software.
*/
`timescale 1ns/100ps

module csm_obs_mux
#(
  parameter int AMP_W = csm_pkg::THR_W + csm_pkg::AMP_FRAC_W  // Amplifier sample width
)
(
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // Register port from digital cores and serial bridge
  input  wire logic             reg_wr_en,
  input  wire logic             reg_rd_en,
  input  wire logic [8:0]       reg_addr,
  input  wire logic             reg_pin_sel,
  input  wire logic [15:0]      reg_wdata,
  output logic [15:0]           reg_rdata,
  output logic                  reg_rd_valid,
  // Channel-4 comparator inputs
  input  wire logic [AMP_W-1:0] ch4_neg_amp_level,
  input  wire logic             ch4_high_compare_in,
  input  wire logic             ch4_low_compare_in,
  // Feedback to the microcore
  output logic                  ch4_high_compare_result,
  output logic                  ch4_low_compare_result,
  output logic                  ch4_negative_compare_result,
  // Negative threshold to the DAC
  output logic [3:0]            negative_threshold_code,
  // Observation pin A controls
  output logic                  pin_a_route_meas1,
  output logic                  pin_a_route_meas3,
  output logic                  pin_a_route_supply,
  output logic                  pin_a_drive_enable,
  output logic [1:0]            pin_a_gain_code,
  output logic                  pin_a_bias_remove,
  // Observation pin B controls
  output logic                  pin_b_route_meas2,
  output logic                  pin_b_route_meas4,
  output logic                  pin_b_route_supply,
  output logic                  pin_b_drive_enable,
  output logic [1:0]            pin_b_gain_code,
  output logic                  pin_b_bias_remove
);

  // Register state
  logic [15:0] cfg_a_ff,  nxt_cfg_a;     // Pin A config word
  logic [15:0] cfg_b_ff,  nxt_cfg_b;     // Pin B config word
  logic [3:0]  thr_ff,    nxt_thr;       // Negative current threshold code

  // Read answer state
  logic [15:0] rdata_ff,  nxt_rdata;     // Read data holding register
  logic        rvalid_ff, nxt_rvalid;    // Read answer strobe

  // Address decode
  logic        hit_cfg;                  // Access to a pin config word
  logic        hit_thr;                  // Access to the threshold word
  logic        wr_cfg_a;                 // Write lands in the pin A word
  logic        wr_cfg_b;                 // Write lands in the pin B word
  logic        wr_thr;                   // Write lands in the threshold word

  // Comparator threshold scaled to the sample grid
  logic [AMP_W-1:0] thr_scaled;

  // Keep only the defined config bits; the rest always reads zero
  function automatic logic [15:0] cfg_store(input logic [15:0] data);
    cfg_store = data & csm_pkg::CFG_WR_MASK;
  endfunction

  // Threshold word keeps its low code bits only
  function automatic logic [3:0] thr_store(input logic [15:0] data);
    thr_store = data[csm_pkg::THR_W-1:0];
  endfunction

  // Decode the shared config offset; pin select picks the word
  always_comb
  begin
    // Offsets compare on the full word address
    hit_cfg  = (reg_addr == csm_pkg::CFG_OFFSET);                // see [RULE_10]
    hit_thr  = (reg_addr == csm_pkg::THR_OFFSET);
    wr_cfg_a = reg_wr_en && hit_cfg && !reg_pin_sel;
    wr_cfg_b = reg_wr_en && hit_cfg && reg_pin_sel;
    // Pin select means nothing at the threshold offset
    wr_thr   = reg_wr_en && hit_thr;
  end

  // Next stored words; unmapped writes leave everything as is
  always_comb
  begin
    nxt_cfg_a = cfg_a_ff;
    nxt_cfg_b = cfg_b_ff;
    nxt_thr   = thr_ff;
    // Pin A word
    if (wr_cfg_a)
    begin
      nxt_cfg_a = cfg_store(reg_wdata);                          // see [RULE_11]
    end
    // Pin B word
    if (wr_cfg_b)
    begin
      nxt_cfg_b = cfg_store(reg_wdata);                          // see [RULE_11]
    end
    // Threshold code, changeable at any time by the microcore
    if (wr_thr)
    begin
      nxt_thr = thr_store(reg_wdata);                            // see [RULE_13]
    end
  end

  // Register the stored words
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cfg_a_ff <= csm_pkg::CFG_RESET;
      cfg_b_ff <= csm_pkg::CFG_RESET;
      thr_ff   <= csm_pkg::THR_RESET;
    end
    else
    begin
      cfg_a_ff <= nxt_cfg_a;
      cfg_b_ff <= nxt_cfg_b;
      thr_ff   <= nxt_thr;
    end
  end

  // Read answer one cycle later; a read in the write cycle sees the old word
  always_comb
  begin
    nxt_rdata  = rdata_ff;
    nxt_rvalid = 1'b0;
    if (reg_rd_en)
    begin
      nxt_rvalid = 1'b1;
      if (hit_cfg)
      begin
        nxt_rdata = reg_pin_sel ? cfg_b_ff : cfg_a_ff;
      end
      else if (hit_thr)
      begin
        nxt_rdata = {12'h000, thr_ff};
      end
      // Unmapped offsets answer zero so a stray read is harmless
      else
      begin
        nxt_rdata = 16'h0000;
      end
    end
  end

  // Register the read answer; data holds until the next read,
  // the valid strobe stands for one cycle only
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rdata_ff  <= 16'h0000;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  // Register outputs, each straight from its flip-flop
  assign reg_rdata               = rdata_ff;
  assign reg_rd_valid            = rvalid_ff;
  assign negative_threshold_code = thr_ff;                       // see [RULE_13]

  // Threshold in sample units; LSB bits of the sample are sub-code fraction
  // Padding follows AMP_W so a wider sample still lines up with the code
  assign thr_scaled = {thr_ff, {(AMP_W-csm_pkg::THR_W){1'b0}}};

  // Negative comparator: strict greater-than, no hysteresis band.
  // Kept combinational so the microcore sees it with no added latency.
  assign ch4_negative_compare_result = (ch4_neg_amp_level > thr_scaled); // see [RULE_01] [RULE_02] [RULE_03]

  // High and low comparators pass straight through to the microcore
  assign ch4_high_compare_result = ch4_high_compare_in;          // see [RULE_03]
  assign ch4_low_compare_result  = ch4_low_compare_in;           // see [RULE_03]

  // Pin A can only carry measurements 1 and 3
  csm_pin_route u_pin_a
  (
    .ref_clk       (ref_clk),
    .rst           (rst),
    .cfg           (cfg_a_ff),
    .route_meas_lo (pin_a_route_meas1),                          // see [RULE_07]
    .route_meas_hi (pin_a_route_meas3),
    .route_supply  (pin_a_route_supply),
    .drive_oe      (pin_a_drive_enable),
    .gain_code     (pin_a_gain_code),
    .bias_remove   (pin_a_bias_remove)
  );

  // Pin B can only carry measurements 2 and 4.
  // Both pins may be enabled at once; a shared ADC relies on the host
  // to enable one at a time, since contention is not blocked here.
  csm_pin_route u_pin_b
  (
    .ref_clk       (ref_clk),
    .rst           (rst),
    .cfg           (cfg_b_ff),
    .route_meas_lo (pin_b_route_meas2),                          // see [RULE_07]
    .route_meas_hi (pin_b_route_meas4),
    .route_supply  (pin_b_route_supply),
    .drive_oe      (pin_b_drive_enable),
    .gain_code     (pin_b_gain_code),
    .bias_remove   (pin_b_bias_remove)
  );

endmodule

// *** hdl/csm_pin_route.sv ***
/*
  One observation pin's multiplexer control decode.
  Assumes the config word is held stable by the caller; the analog mux
  follows the registered one-hot selects and the drive enable.
*/
`timescale 1ns/100ps

module csm_pin_route
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Configuration word of this pin
  input  wire logic [15:0] cfg,
  // Mux controls to the analog path
  output logic             route_meas_lo,
  output logic             route_meas_hi,
  output logic             route_supply,
  output logic             drive_oe,
  output logic [1:0]       gain_code,
  output logic             bias_remove
);

  logic       route_lo_ff,  nxt_route_lo;   // First measurement selected
  logic       route_hi_ff,  nxt_route_hi;   // Second measurement selected
  logic       supply_ff,    nxt_supply;     // Supply check selected
  logic       oe_ff,        nxt_oe;         // Buffer drives the pin
  logic [1:0] gain_ff,      nxt_gain;       // Amplifier gain code
  logic       bias_ff,      nxt_bias;       // Bias removal for high gains

  // Decode source and enable into one-hot selects; gain passes as a two-bit code
  always_comb
  begin
    nxt_route_lo = 1'b0;
    nxt_route_hi = 1'b0;
    nxt_supply   = 1'b0;
    nxt_oe       = 1'b0;
    nxt_gain     = csm_pkg::cfg_gain(cfg);                       // see [RULE_09] [RULE_10]
    nxt_bias     = (nxt_gain == csm_pkg::GAIN_3P0) || (nxt_gain == csm_pkg::GAIN_5P33);
    // Disabled pin floats whatever the source code
    if (csm_pkg::cfg_enable(cfg))                                // see [RULE_06]
    begin
      unique case (csm_pkg::cfg_source(cfg))
        csm_pkg::SRC_MEAS_LO:
        begin
          nxt_route_lo = 1'b1;                                   // see [RULE_04] [RULE_05]
          nxt_oe       = 1'b1;
        end
        csm_pkg::SRC_MEAS_HI:
        begin
          nxt_route_hi = 1'b1;                                   // see [RULE_04] [RULE_05]
          nxt_oe       = 1'b1;
        end
        csm_pkg::SRC_SUPPLY:
        begin
          nxt_supply   = 1'b1;                                   // see [RULE_08]
          nxt_oe       = 1'b1;
        end
        // Reserved codes: keep buffer off so nothing undefined hits the ADC
        default:
        begin
          nxt_oe       = 1'b0;                                   // see [RULE_14]
        end
      endcase
    end
  end

  // Register controls so mux switching is glitch free
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      route_lo_ff <= 1'b0;
      route_hi_ff <= 1'b0;
      supply_ff   <= 1'b0;
      oe_ff       <= 1'b0;
      gain_ff     <= csm_pkg::GAIN_1P33;
      bias_ff     <= 1'b0;
    end
    else
    begin
      route_lo_ff <= nxt_route_lo;
      route_hi_ff <= nxt_route_hi;
      supply_ff   <= nxt_supply;
      oe_ff       <= nxt_oe;
      gain_ff     <= nxt_gain;
      bias_ff     <= nxt_bias;
    end
  end

  assign route_meas_lo = route_lo_ff;
  assign route_meas_hi = route_hi_ff;
  assign route_supply  = supply_ff;
  assign drive_oe      = oe_ff;
  assign gain_code     = gain_ff;
  assign bias_remove   = bias_ff;

endmodule

// *** hdl/csm_pkg.sv ***
/*
  Constants, field layouts and decode helpers for the observation pin
  selection logic of the current sense block.
  Assumes the configuration words are written by the internal digital cores
  or the serial port bridge over a plain word write port.
*/
// Operation
// [RULE_01] Negative comparator high when amplifier exceeds threshold
// [RULE_02] Comparator toggles at the DAC threshold crossing
// [RULE_03] Channel-4 comparator results go straight to microcore
// [RULE_04] Pin A: 000 measurement 1, 001 measurement 3
// [RULE_05] Pin B: 000 measurement 2, 001 measurement 4
// [RULE_06] Enable bit low forces pin high impedance
// [RULE_07] No cross-routing of measurements between pins
// [RULE_08] Code 101 enabled drives internal 2.5 V supply
// [RULE_09] Two-bit gain code selects one of four gains
// [RULE_10] Source and gain fields share pin's config register
// [RULE_11] Digital cores control both pin multiplexers
// [RULE_12] Shared converter input: host enables one pin
// [RULE_13] Negative threshold is 4-bit run-time code
// [RULE_14] Reserved source codes keep pin high impedance
package csm_pkg;

  // Register map (both config words share one printed offset)
  localparam logic [8:0]  CFG_OFFSET      = 9'h1aa;  // Pin config word offset
  localparam logic [8:0]  THR_OFFSET      = 9'h1ab;  // Negative threshold word offset
  localparam int          REG_W           = 16;      // Register word width
  localparam logic [15:0] CFG_RESET       = 16'h0000;
  localparam logic [3:0]  THR_RESET       = 4'h0;

  // Config word layout
  localparam int          SRC_LSB         = 0;       // Source select field [2:0]
  localparam int          EN_BIT          = 3;       // Drive enable bit
  localparam int          GAIN_LSB        = 4;       // Gain select field [5:4]
  localparam logic [15:0] CFG_WR_MASK     = 16'h003f; // Writable bits, rest read zero
  localparam logic [15:0] THR_WR_MASK     = 16'h000f;

  // Source select codes
  localparam logic [2:0]  SRC_MEAS_LO     = 3'h0;    // First measurement of the pin
  localparam logic [2:0]  SRC_MEAS_HI     = 3'h1;    // Second measurement of the pin
  localparam logic [2:0]  SRC_SUPPLY      = 3'h5;    // Internal 2.5 V supply

  // Gain codes
  localparam logic [1:0]  GAIN_1P33       = 2'h0;
  localparam logic [1:0]  GAIN_2P0        = 2'h1;
  localparam logic [1:0]  GAIN_3P0        = 2'h2;
  localparam logic [1:0]  GAIN_5P33       = 2'h3;

  // Threshold and amplifier sample widths
  localparam int          THR_W           = 4;       // DAC code width
  localparam int          AMP_FRAC_W      = 4;       // Sub-LSB bits of amplifier sample

  // Field extraction, used by both pins
  function automatic logic [2:0] cfg_source(input logic [15:0] cfg);
    cfg_source = cfg[SRC_LSB +: 3];
  endfunction

  function automatic logic cfg_enable(input logic [15:0] cfg);
    cfg_enable = cfg[EN_BIT];
  endfunction

  function automatic logic [1:0] cfg_gain(input logic [15:0] cfg);
    cfg_gain = cfg[GAIN_LSB +: 2];
  endfunction

endpackage

// *** sim/csm_adc_model.sv ***
/*
  Host converter input shared by both observation pins.
  Assumes both pins meet on one input that has a weak pull-down.
*/
`timescale 1ns/100ps

module csm_adc_model
(
  // Pin buffer enables and supply routes
  input  wire logic       pin_a_drive_enable,
  input  wire logic       pin_a_route_supply,
  input  wire logic       pin_b_drive_enable,
  input  wire logic       pin_b_route_supply,
  // What the converter sees: 0 pulled low, 1 pin a, 2 pin b, 3 clash
  output logic [1:0]      adc_source,
  output logic            adc_sees_supply
);
  // Released input falls to the pull-down; two drivers is a host fault
  always_comb
  begin
    adc_source = {pin_b_drive_enable, pin_a_drive_enable};
  end
  // Connection check is only meaningful with a single driver
  assign adc_sees_supply = (adc_source == 2'h1) ? pin_a_route_supply :
                           (adc_source == 2'h2) ? pin_b_route_supply : 1'b0;
endmodule

// *** sim/csm_obs_mux_assertions.sv ***
/*
  Checker for the observation pin mux: pin decode, gain, feedback and reads.
  Assumes it is bound to csm_obs_mux and sees only its ports.
*/
`timescale 1ns/100ps

module csm_obs_mux_chk
#(
  parameter int AMP_W = 8  // Amplifier sample width
)
(
  // Clock, reset and register port
  input wire logic             ref_clk,
  input wire logic             rst,
  input wire logic             reg_wr_en,
  input wire logic             reg_rd_en,
  input wire logic [8:0]       reg_addr,
  input wire logic             reg_pin_sel,
  input wire logic [15:0]      reg_wdata,
  input wire logic             reg_rd_valid,
  // Comparator path
  input wire logic [AMP_W-1:0] ch4_neg_amp_level,
  input wire logic             ch4_high_compare_in,
  input wire logic             ch4_high_compare_result,
  input wire logic             ch4_negative_compare_result,
  input wire logic [3:0]       negative_threshold_code,
  // Pin controls
  input wire logic             pin_a_route_meas1,
  input wire logic             pin_a_route_meas3,
  input wire logic             pin_a_route_supply,
  input wire logic             pin_a_drive_enable,
  input wire logic [1:0]       pin_a_gain_code,
  input wire logic             pin_a_bias_remove,
  input wire logic             pin_b_route_meas2,
  input wire logic             pin_b_route_meas4,
  input wire logic             pin_b_route_supply,
  input wire logic             pin_b_drive_enable
);
  logic [15:0] wd_q1_ff;  // Write data one edge back
  logic [15:0] wd_q2_ff;  // Two edges back, lines up with pin controls

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Delay line only, no reset needed
  always_ff @(posedge ref_clk)
  begin
    wd_q1_ff <= reg_wdata;
    wd_q2_ff <= wd_q1_ff;
  end

  // Expected {lo, hi, supply, enable}; reserved codes stay off
  function automatic logic [3:0] route_exp(input logic [15:0] w);
    if (!w[3])
      return 4'h0;
    case (w[2:0])
      3'h0:    return 4'h9;
      3'h1:    return 4'h5;
      3'h5:    return 4'h3;
      default: return 4'h0;
    endcase
  endfunction

  sequence wr_a_s;
    reg_wr_en && reg_addr == 9'h1aa && !reg_pin_sel;
  endsequence
  sequence wr_b_s;
    reg_wr_en && reg_addr == 9'h1aa && reg_pin_sel;
  endsequence
  sequence wr_thr_s;
    reg_wr_en && reg_addr == 9'h1ab;
  endsequence

  pin_a_decode_a : assert property (
    wr_a_s |-> ##2
      {pin_a_route_meas1, pin_a_route_meas3, pin_a_route_supply, pin_a_drive_enable} == route_exp(wd_q2_ff))
    else $error("pin a decode wrong");
  pin_b_decode_a : assert property (
    wr_b_s |-> ##2
      {pin_b_route_meas2, pin_b_route_meas4, pin_b_route_supply, pin_b_drive_enable} == route_exp(wd_q2_ff))
    else $error("pin b decode wrong");
  gain_load_a : assert property (wr_a_s |-> ##2 pin_a_gain_code == wd_q2_ff[5:4])
    else $error("pin a gain not loaded");
  bias_follow_a : assert property (pin_a_bias_remove == pin_a_gain_code[1])
    else $error("bias removal does not follow gain");
  hiz_off_a : assert property (
    !pin_a_drive_enable |-> !(pin_a_route_meas1 || pin_a_route_meas3 || pin_a_route_supply))
    else $error("route active while pin released");
  fb_copy_a : assert property (ch4_high_compare_result == ch4_high_compare_in)
    else $error("high feedback not direct");
  neg_cmp_a : assert property (
    ch4_negative_compare_result == (ch4_neg_amp_level > {negative_threshold_code, {(AMP_W-4){1'b0}}}))
    else $error("negative compare wrong");
  thr_load_a : assert property (wr_thr_s |=> negative_threshold_code == wd_q1_ff[3:0])
    else $error("threshold not loaded");
  rd_valid_a : assert property (reg_rd_valid == $past(reg_rd_en))
    else $error("read valid timing wrong");
endmodule

bind csm_obs_mux csm_obs_mux_chk #(.AMP_W(AMP_W)) u_csm_obs_mux_chk (.ref_clk, .rst, .reg_wr_en, .reg_rd_en,
  .reg_addr, .reg_pin_sel, .reg_wdata, .reg_rd_valid, .ch4_neg_amp_level, .ch4_high_compare_in,
  .ch4_high_compare_result, .ch4_negative_compare_result, .negative_threshold_code, .pin_a_route_meas1,
  .pin_a_route_meas3, .pin_a_route_supply, .pin_a_drive_enable, .pin_a_gain_code, .pin_a_bias_remove,
  .pin_b_route_meas2, .pin_b_route_meas4, .pin_b_route_supply, .pin_b_drive_enable);

// *** sim/tb_csm_obs_mux.sv ***
/*
  Self-checking bench for the observation pin mux.
  Assumes the design package is compiled first.
*/
`timescale 1ns/100ps

module tb_csm_obs_mux;
  logic        ref_clk = 1'b0, rst = 1'b1, reg_wr_en = 1'b0, reg_rd_en = 1'b0, reg_pin_sel = 1'b0;
  logic [8:0]  reg_addr = 9'h000;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic [7:0]  ch4_neg_amp_level = 8'h00;
  logic        ch4_high_compare_in = 1'b0, ch4_low_compare_in = 1'b0;
  logic        reg_rd_valid, ch4_high_compare_result, ch4_low_compare_result, ch4_negative_compare_result;
  logic [3:0]  negative_threshold_code;
  logic        pin_a_route_meas1, pin_a_route_meas3, pin_a_route_supply, pin_a_drive_enable, pin_a_bias_remove;
  logic        pin_b_route_meas2, pin_b_route_meas4, pin_b_route_supply, pin_b_drive_enable, pin_b_bias_remove;
  logic [1:0]  pin_a_gain_code, pin_b_gain_code, adc_source;
  logic        adc_sees_supply;
  int          bad_count = 0, checks = 0, cycles = 0;
  wire  [3:0]  route_a = {pin_a_route_meas1, pin_a_route_meas3, pin_a_route_supply, pin_a_drive_enable};
  wire  [3:0]  route_b = {pin_b_route_meas2, pin_b_route_meas4, pin_b_route_supply, pin_b_drive_enable};

  csm_obs_mux u_csm_obs_mux (.ref_clk, .rst, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_pin_sel, .reg_wdata,
    .reg_rdata, .reg_rd_valid, .ch4_neg_amp_level, .ch4_high_compare_in, .ch4_low_compare_in,
    .ch4_high_compare_result, .ch4_low_compare_result, .ch4_negative_compare_result, .negative_threshold_code,
    .pin_a_route_meas1, .pin_a_route_meas3, .pin_a_route_supply, .pin_a_drive_enable, .pin_a_gain_code,
    .pin_a_bias_remove, .pin_b_route_meas2, .pin_b_route_meas4, .pin_b_route_supply, .pin_b_drive_enable,
    .pin_b_gain_code, .pin_b_bias_remove);
  csm_adc_model u_csm_adc_model (.pin_a_drive_enable, .pin_a_route_supply, .pin_b_drive_enable,
    .pin_b_route_supply, .adc_source, .adc_sees_supply);

  always #5 ref_clk = ~ref_clk;

  // Hang guard, far above the roughly 190 cycles the tests need
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      bad_count++;
      complete_run();
    end
  end

  task automatic complete_run;
    $display("counts: %0d checks, %0d mismatches", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Strobe held for exactly the one edge that takes it
  task automatic reg_write(input logic [8:0] addr, input logic sel, input logic [15:0] data);
    @(posedge ref_clk);
    reg_wr_en   <= 1'b1;
    reg_addr    <= addr;
    reg_pin_sel <= sel;
    reg_wdata   <= data;
    @(posedge ref_clk);
    reg_wr_en <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  task automatic reg_read(input logic [8:0] addr, input logic sel, input logic [15:0] exp);
    @(posedge ref_clk);
    reg_rd_en   <= 1'b1;
    reg_addr    <= addr;
    reg_pin_sel <= sel;
    @(posedge ref_clk);
    reg_rd_en <= 1'b0;
    #1;
    // Answer stands in the cycle after the read edge only
    check({15'h0, reg_rd_valid}, 16'h0001);
    check(reg_rdata, exp);
    @(posedge ref_clk);
    #1;
    check({15'h0, reg_rd_valid}, 16'h0000);
  endtask

  task automatic t_reset;
    check({8'h0, route_a, route_b}, 16'h0000);
    reg_read(9'h1aa, 1'b1, 16'h0000);
    $display("test reset done");
  endtask

  // Every source code and gain on both pins, the other pin must stay off
  task automatic t_route;
    logic [3:0]  exp;
    logic [15:0] w;
    for (int p = 0; p < 2; p++)
    begin
      for (int c = 0; c < 8; c++)
      begin
        w = {10'h0, c[1:0], 1'b1, c[2:0]};
        reg_write(9'h1aa, p[0], w);
        case (c)
          0:       exp = 4'h9;
          1:       exp = 4'h5;
          5:       exp = 4'h3;
          default: exp = 4'h0;
        endcase
        check({12'h0, p ? route_b : route_a}, {12'h0, exp});
        check({12'h0, p ? route_a : route_b}, 16'h0000);
        check({14'h0, p ? pin_b_gain_code : pin_a_gain_code}, {14'h0, c[1:0]});
        check({15'h0, p ? pin_b_bias_remove : pin_a_bias_remove}, {15'h0, c[1]});
        reg_read(9'h1aa, p[0], w);
      end
      reg_write(9'h1aa, p[0], 16'h0001);
      check({12'h0, p ? route_b : route_a}, 16'h0000);
    end
    $display("test route done");
  endtask

  // Unused bits read zero, unmapped place answers zero
  task automatic t_regs;
    reg_write(9'h1aa, 1'b0, 16'hffff);
    reg_read(9'h1aa, 1'b0, 16'h003f);
    reg_write(9'h1aa, 1'b0, 16'h0000);
    reg_write(9'h1ab, 1'b1, 16'hffff);
    reg_read(9'h1ab, 1'b0, 16'h000f);
    reg_read(9'h1ac, 1'b0, 16'h0000);
    $display("test regs done");
  endtask

  task automatic t_cmp;
    logic [7:0] lv [4] = '{8'h4f, 8'h50, 8'h51, 8'hff};
    logic       ex [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    reg_write(9'h1ab, 1'b0, 16'h0005);
    check({12'h0, negative_threshold_code}, 16'h0005);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge ref_clk);
      ch4_neg_amp_level   <= lv[i];
      ch4_high_compare_in <= i[0];
      ch4_low_compare_in  <= ~i[0];
      @(posedge ref_clk);
      #1;
      check({15'h0, ch4_negative_compare_result}, {15'h0, ex[i]});
      check({14'h0, ch4_high_compare_result, ch4_low_compare_result}, {14'h0, i[0], ~i[0]});
    end
    // Lower threshold at run time: a level below the old one now trips
    reg_write(9'h1ab, 1'b0, 16'h0004);
    @(posedge ref_clk);
    ch4_neg_amp_level <= 8'h4f;
    @(posedge ref_clk);
    #1;
    check({15'h0, ch4_negative_compare_result}, 16'h0001);
    $display("test comparator done");
  endtask

  // One pin at a time on the shared converter input
  task automatic t_adc;
    reg_write(9'h1aa, 1'b0, 16'h000d);
    check({14'h0, adc_source}, 16'h0001);
    check({15'h0, adc_sees_supply}, 16'h0001);
    reg_write(9'h1aa, 1'b0, 16'h0000);
    reg_write(9'h1aa, 1'b1, 16'h0009);
    check({12'h0, route_b}, 16'h0005);
    check({14'h0, adc_source, adc_sees_supply}, 16'h0004);
    $display("test converter done");
  endtask

  initial
  begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    t_reset();
    t_route();
    t_regs();
    t_cmp();
    t_adc();
    complete_run();
  end
endmodule
